// file: src/audio_port_mux_pkg.sv
// constants and carrier types for the dual audio port pin mux
//
// Contract
// - reg 27 bit 2 set drives primary word clock pin, clear takes it from host
// - reg 27 bit 3 set drives primary bit clock pin, clear takes it from host
// - reg 33 bits 5-4 pick primary word clock source: playback, record, secondary
// - reg 33 bit 7 picks primary bit clock source: internal or secondary
// - reg 32 bit 0 feeds interface from primary data in or secondary data in
// - reg 53 bits 3-1: 001 primary data, 111 secondary frame, 110 secondary bit clock
// - reg 33 bit 1 sends interface data or secondary data in to data out pin
// - reg 31 bits 4-2: 000 secondary frame clock on io pin one, 011 on data out; only 000 is decoded, other codes give zero
// - reg 33 bits 3-2 pick secondary frame clock: playback, record, primary frame
// - reg 31 bits 7-5: 000 secondary bit clock on io pin one, 011 on data out; only 000 is decoded, other codes give zero
// - reg 33 bit 6 picks secondary bit clock: primary or internal bit clock
// - reg 31 bits 1-0 at 00 take secondary data in from io pin one
// - reg 51 bits 5-2 set io pin one function: 1001,1000,0001,1011,0111
// - reg 33 bit 0 sends primary data in or interface data to secondary out
// - reg 32 bits 7-5 at 000 tie record frame clock to io pin one
// - reg 32 bit 1 picks internal record frame: playback or record frame clock
package audio_port_mux_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] IFACE_CTRL_OFS = 8'h1b;
	localparam logic [7:0] SEC_PINS_OFS = 8'h1f;
	localparam logic [7:0] DIN_SEL_OFS = 8'h20;
	localparam logic [7:0] CLK_SRC_OFS = 8'h21;
	localparam logic [7:0] IO_ONE_FUNC_OFS = 8'h33;
	localparam logic [7:0] DOUT_FUNC_OFS = 8'h35;
	localparam logic [7:0] STATUS_OFS = 8'h3c;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] IFACE_CTRL_RST = 8'h00;
	localparam logic [7:0] SEC_PINS_RST = 8'h00;
	localparam logic [7:0] DIN_SEL_RST = 8'h00;
	localparam logic [7:0] CLK_SRC_RST = 8'h00;
	localparam logic [7:0] IO_ONE_FUNC_RST = 8'h00;
	localparam logic [7:0] DOUT_FUNC_RST = 8'h02;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int WCLK_DIR_BIT = 2;
	localparam int BCLK_DIR_BIT = 3;
	localparam int PRI_BCLK_SRC_BIT = 7;
	localparam int SEC_BCLK_SRC_BIT = 6;
	localparam int PRI_WCLK_SRC_LSB = 4;
	localparam int SEC_WCLK_SRC_LSB = 2;
	localparam int PRI_DOUT_SRC_BIT = 1;
	localparam int SEC_DOUT_SRC_BIT = 0;
	localparam int DIN_SRC_BIT = 0;
	localparam int REC_FRAME_SRC_BIT = 1;
	localparam int REC_FRAME_PIN_LSB = 5;
	localparam int SEC_BCLK_PIN_LSB = 5;
	localparam int SEC_WCLK_PIN_LSB = 2;
	localparam int SEC_DIN_PIN_LSB = 0;
	localparam int IO_ONE_FUNC_LSB = 2;
	localparam int DOUT_FUNC_LSB = 1;

	// ------------------------------------------------------------
	// codes
	// ------------------------------------------------------------
	localparam logic [1:0] WSRC_PLAYBACK = 2'h0;
	localparam logic [1:0] WSRC_RECORD = 2'h1;
	localparam logic [2:0] PIN_IO_ONE = 3'h0;
	localparam logic [2:0] PIN_DOUT = 3'h3;
	localparam logic [1:0] SEC_DIN_IO_ONE = 2'h0;
	localparam logic [2:0] DOUT_PRI_DATA = 3'h1;
	localparam logic [2:0] DOUT_SEC_WCLK = 3'h7;
	localparam logic [2:0] DOUT_SEC_BCLK = 3'h6;
	localparam logic [3:0] IO_SEC_WCLK = 4'h9;
	localparam logic [3:0] IO_SEC_BCLK = 4'h8;
	localparam logic [3:0] IO_SEC_INPUT = 4'h1;
	localparam logic [3:0] IO_SEC_DOUT = 4'hb;
	localparam logic [3:0] IO_REC_FRAME = 4'h7;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic out;
		logic oe_n;
	} pin_drive_t;

	typedef struct packed {
		logic frame;
		logic rec_frame;
		logic bit_clk;
		logic data;
	} iface_in_t;

	typedef struct packed {
		logic play_rate;
		logic rec_rate;
		logic bit_clk;
		logic data;
	} iface_src_t;

endpackage

// file: src/dual_audio_port_mux.sv
// codec-side routing of one audio serial interface to a primary and a secondary port
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dual_audio_port_mux (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// primary port pins
	input wire logic word_clock_pin_in,
	output audio_port_mux_pkg::pin_drive_t word_clock_pin,
	input wire logic bit_clock_pin_in,
	output audio_port_mux_pkg::pin_drive_t bit_clock_pin,
	input wire logic serial_data_in_pin,
	output logic serial_data_out_pin,
	// shared io pin
	input wire logic general_io_pin_one_in,
	output audio_port_mux_pkg::pin_drive_t general_io_pin_one,
	// internal audio interface
	input wire audio_port_mux_pkg::iface_src_t iface_src,
	output audio_port_mux_pkg::iface_in_t iface_in,
	// captured serial bits
	output logic bit_valid,
	output logic bit_value,
	input wire logic bit_ready,
	output logic bit_stall
);
	import audio_port_mux_pkg::*;

	// ------------------------------------------------------------
	// routing registers
	// ------------------------------------------------------------
	logic [7:0] iface_ctrl_reg;
	logic [7:0] sec_pins_reg;
	logic [7:0] din_sel_reg;
	logic [7:0] clk_src_reg;
	logic [7:0] io_one_func_reg;
	logic [7:0] dout_func_reg;
	logic [7:0] overrun_reg;
	logic [7:0] rdata_next;

	always_ff @(posedge clk) begin
		if (rst) begin
			iface_ctrl_reg <= IFACE_CTRL_RST;
			sec_pins_reg <= SEC_PINS_RST;
			din_sel_reg <= DIN_SEL_RST;
			clk_src_reg <= CLK_SRC_RST;
			io_one_func_reg <= IO_ONE_FUNC_RST;
			dout_func_reg <= DOUT_FUNC_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				IFACE_CTRL_OFS: iface_ctrl_reg <= reg_wdata;
				SEC_PINS_OFS: sec_pins_reg <= reg_wdata;
				DIN_SEL_OFS: din_sel_reg <= reg_wdata;
				CLK_SRC_OFS: clk_src_reg <= reg_wdata;
				IO_ONE_FUNC_OFS: io_one_func_reg <= reg_wdata;
				DOUT_FUNC_OFS: dout_func_reg <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_comb begin
		case (reg_addr)
			IFACE_CTRL_OFS: rdata_next = iface_ctrl_reg;
			SEC_PINS_OFS: rdata_next = sec_pins_reg;
			DIN_SEL_OFS: rdata_next = din_sel_reg;
			CLK_SRC_OFS: rdata_next = clk_src_reg;
			IO_ONE_FUNC_OFS: rdata_next = io_one_func_reg;
			DOUT_FUNC_OFS: rdata_next = dout_func_reg;
			STATUS_OFS: rdata_next = overrun_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// host clocks are asynchronous; two stages before any use
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	logic pri_wclk;
	logic pri_bclk;
	logic pri_din;
	logic io_one;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_reg <= 4'h0;
			pin_sync_reg <= 4'h0;
		end else begin
			pin_meta_reg <= {general_io_pin_one_in, serial_data_in_pin,
				bit_clock_pin_in, word_clock_pin_in};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign pri_wclk = pin_sync_reg[0];
	assign pri_bclk = pin_sync_reg[1];
	assign pri_din = pin_sync_reg[2];
	assign io_one = pin_sync_reg[3];

	// ------------------------------------------------------------
	// routing
	// ------------------------------------------------------------
	logic [1:0] pri_wsrc;
	logic [1:0] sec_wsrc;
	logic [3:0] io_func;
	logic [2:0] dout_func;
	logic sec_wclk_in;
	logic sec_bclk_in;
	logic sec_din;
	logic sec_wclk_out;
	logic sec_bclk_out;
	logic sec_dout;
	logic rec_frame_pin;
	pin_drive_t wclk_next;
	pin_drive_t bclk_next;
	pin_drive_t io_next;
	iface_in_t iface_next;
	logic dout_next;

	assign pri_wsrc = clk_src_reg[PRI_WCLK_SRC_LSB +: 2];
	assign sec_wsrc = clk_src_reg[SEC_WCLK_SRC_LSB +: 2];
	assign io_func = io_one_func_reg[IO_ONE_FUNC_LSB +: 4];
	assign dout_func = dout_func_reg[DOUT_FUNC_LSB +: 3];

	always_comb begin
		// secondary inputs arrive on io pin one only when selected there
		sec_wclk_in = (sec_pins_reg[SEC_WCLK_PIN_LSB +: 3] == PIN_IO_ONE) & io_one;
		sec_bclk_in = (sec_pins_reg[SEC_BCLK_PIN_LSB +: 3] == PIN_IO_ONE) & io_one;
		sec_din = (sec_pins_reg[SEC_DIN_PIN_LSB +: 2] == SEC_DIN_IO_ONE) & io_one;
		case (sec_wsrc)
			WSRC_PLAYBACK: sec_wclk_out = iface_src.play_rate;
			WSRC_RECORD: sec_wclk_out = iface_src.rec_rate;
			default: sec_wclk_out = pri_wclk;
		endcase
		sec_bclk_out = clk_src_reg[SEC_BCLK_SRC_BIT] ? iface_src.bit_clk : pri_bclk;
		sec_dout = clk_src_reg[SEC_DOUT_SRC_BIT] ? iface_src.data : pri_din;
		// primary word clock pin
		wclk_next.oe_n = ~iface_ctrl_reg[WCLK_DIR_BIT];
		case (pri_wsrc)
			WSRC_PLAYBACK: wclk_next.out = iface_src.play_rate;
			WSRC_RECORD: wclk_next.out = iface_src.rec_rate;
			default: wclk_next.out = sec_wclk_in;
		endcase
		// primary bit clock pin
		bclk_next.oe_n = ~iface_ctrl_reg[BCLK_DIR_BIT];
		bclk_next.out = clk_src_reg[PRI_BCLK_SRC_BIT] ? sec_bclk_in : iface_src.bit_clk;
		// data out pin
		case (dout_func)
			DOUT_PRI_DATA: dout_next = clk_src_reg[PRI_DOUT_SRC_BIT] ? sec_din
				: iface_src.data;
			DOUT_SEC_WCLK: dout_next = sec_wclk_out;
			DOUT_SEC_BCLK: dout_next = sec_bclk_out;
			default: dout_next = 1'b0;
		endcase
		// io pin one; unknown codes leave it as an input
		io_next.oe_n = 1'b0;
		case (io_func)
			IO_SEC_WCLK: io_next.out = sec_wclk_out;
			IO_SEC_BCLK: io_next.out = sec_bclk_out;
			IO_SEC_DOUT: io_next.out = sec_dout;
			IO_REC_FRAME: io_next.out = iface_src.rec_rate;
			default: begin
				io_next.out = 1'b0;
				io_next.oe_n = 1'b1;
			end
		endcase
		// record frame clock pin: driven value or host level
		if (din_sel_reg[REC_FRAME_PIN_LSB +: 3] == PIN_IO_ONE) begin
			rec_frame_pin = (io_func == IO_REC_FRAME) ? iface_src.rec_rate : io_one;
		end else begin
			rec_frame_pin = iface_src.rec_rate;
		end
		// internal interface sees the level of whichever side drives the pin
		iface_next.frame = iface_ctrl_reg[WCLK_DIR_BIT] ? wclk_next.out : pri_wclk;
		iface_next.bit_clk = iface_ctrl_reg[BCLK_DIR_BIT] ? bclk_next.out : pri_bclk;
		iface_next.rec_frame = din_sel_reg[REC_FRAME_SRC_BIT] ? rec_frame_pin
			: iface_next.frame;
		iface_next.data = din_sel_reg[DIN_SRC_BIT] ? sec_din : pri_din;
	end

	// one register stage: a write shows at the pins on the following edge
	always_ff @(posedge clk) begin
		if (rst) begin
			word_clock_pin <= '{out: 1'b0, oe_n: 1'b1};
			bit_clock_pin <= '{out: 1'b0, oe_n: 1'b1};
			general_io_pin_one <= '{out: 1'b0, oe_n: 1'b1};
			serial_data_out_pin <= 1'b0;
			iface_in <= '0;
		end else begin
			word_clock_pin <= wclk_next;
			bit_clock_pin <= bclk_next;
			general_io_pin_one <= io_next;
			serial_data_out_pin <= dout_next;
			iface_in <= iface_next;
		end
	end

	// ------------------------------------------------------------
	// two-entry bit buffer
	// ------------------------------------------------------------
	// head slot feeds valid and value; second slot holds one more bit and drives the stall flag
	logic [1:0] slot_valid_reg;
	logic [1:0] slot_bit_reg;
	logic push;
	logic pop;
	logic bclk_rise;

	assign bclk_rise = iface_next.bit_clk & ~iface_in.bit_clk;
	assign pop = slot_valid_reg[0] & bit_ready;
	assign push = bclk_rise & ~slot_valid_reg[1];

	always_ff @(posedge clk) begin
		if (rst) begin
			slot_valid_reg <= 2'h0;
			slot_bit_reg <= 2'h0;
		end else begin
			case ({push, pop})
				2'b10: begin
					slot_valid_reg[slot_valid_reg[0]] <= 1'b1;
					slot_bit_reg[slot_valid_reg[0]] <= iface_next.data;
				end
				2'b01: begin
					slot_valid_reg <= {1'b0, slot_valid_reg[1]};
					slot_bit_reg[0] <= slot_bit_reg[1];
				end
				2'b11: begin
					slot_valid_reg <= {1'b0, 1'b1};
					slot_bit_reg[0] <= slot_valid_reg[1] ? slot_bit_reg[1] : iface_next.data;
					slot_bit_reg[1] <= iface_next.data;
					slot_valid_reg[1] <= slot_valid_reg[1];
				end
				default: begin
				end
			endcase
		end
	end

	assign bit_valid = slot_valid_reg[0];
	assign bit_value = slot_bit_reg[0];
	assign bit_stall = slot_valid_reg[1];

	// a bit edge that finds the buffer full is counted, saturating
	always_ff @(posedge clk) begin
		if (rst) begin
			overrun_reg <= 8'h00;
		end else if (bclk_rise & slot_valid_reg[1] & (overrun_reg != 8'hff)) begin
			overrun_reg <= overrun_reg + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_wclk_dir: assert property (
		reg_wr && reg_addr == IFACE_CTRL_OFS ##1 !reg_wr
		|=> word_clock_pin.oe_n == ~$past(reg_wdata[WCLK_DIR_BIT], 2))
		else $error("word clock direction does not follow control");
	chk_bclk_dir: assert property (
		reg_wr && reg_addr == IFACE_CTRL_OFS ##1 !reg_wr
		|=> bit_clock_pin.oe_n == ~$past(reg_wdata[BCLK_DIR_BIT], 2))
		else $error("bit clock direction does not follow control");
	chk_pri_wclk_src: assert property (
		$past(pri_wsrc) == WSRC_RECORD |-> word_clock_pin.out == $past(iface_src.rec_rate))
		else $error("primary word clock not from record rate");
	chk_pri_bclk_src: assert property (
		!$past(clk_src_reg[PRI_BCLK_SRC_BIT]) |-> bit_clock_pin.out == $past(iface_src.bit_clk))
		else $error("primary bit clock not internal");
	chk_din_route: assert property (
		!$past(din_sel_reg[DIN_SRC_BIT]) |-> iface_in.data == $past(pin_sync_reg[2]))
		else $error("interface data not from primary input");
	chk_dout_func: assert property (
		$past(dout_func) == DOUT_SEC_BCLK |-> serial_data_out_pin == $past(sec_bclk_out))
		else $error("data out pin not carrying secondary bit clock");
	chk_dout_pass: assert property (
		$past(dout_func) == DOUT_PRI_DATA && $past(clk_src_reg[PRI_DOUT_SRC_BIT])
		|-> serial_data_out_pin == $past(sec_din))
		else $error("pass-through to data out broken");
	chk_io_input: assert property (
		$past(io_func) == IO_SEC_INPUT |-> general_io_pin_one.oe_n)
		else $error("io pin one driven while set as input");
	chk_rec_frame: assert property (
		!$past(din_sel_reg[REC_FRAME_SRC_BIT]) |-> iface_in.rec_frame == iface_in.frame)
		else $error("record frame not reusing playback frame");
	chk_buf_stall: assert property (
		bit_valid && !bit_ready |=> bit_valid && bit_value == $past(bit_value))
		else $error("buffered bit lost during stall");

	cov_pri_master: cover property (!word_clock_pin.oe_n && !bit_clock_pin.oe_n);
	cov_sec_on_io: cover property (!general_io_pin_one.oe_n ##1 general_io_pin_one.out);
	cov_buf_full: cover property (bit_stall ##1 bit_ready);
	cov_overrun: cover property (overrun_reg != 8'h00);

endmodule
`default_nettype wire

// file: tb/host_port_model.sv
// primary host processor model: link bit clock, frame clock and serial data
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	// control from bench
	input wire logic run,
	input wire logic data_bit,
	// device drive on primary clock pins
	input wire audio_port_mux_pkg::pin_drive_t word_drv,
	input wire audio_port_mux_pkg::pin_drive_t bit_drv,
	// resolved levels and host drive
	output logic word_lvl,
	output logic bit_lvl,
	output logic data_lvl,
	output logic host_word,
	output var logic host_bit
);
	import audio_port_mux_pkg::*;
	logic [3:0] rise_cnt = 4'h0;
	logic data_q = 1'b0;
	initial host_bit = 1'b0;
	// link clock stands still while run is low; a high phase is always finished
	always begin
		#400;
		if (run || host_bit) begin
			host_bit = ~host_bit;
		end
	end
	always @(posedge host_bit) begin
		rise_cnt <= rise_cnt + 4'h1;
	end
	// data moves on the falling edge so it is steady around the rising one
	always @(negedge host_bit) begin
		data_q <= data_bit;
	end
	assign data_lvl = (run || host_bit) ? data_q : data_bit;
	assign host_word = rise_cnt[3];
	// host lets go of a clock pin while the device drives it
	assign word_lvl = (word_drv.oe_n === 1'b0) ? word_drv.out : host_word;
	assign bit_lvl = (bit_drv.oe_n === 1'b0) ? bit_drv.out : host_bit;
endmodule
`default_nettype wire

// file: tb/dual_audio_port_mux_bench.sv
// self-checking bench for the dual audio port pin mux
`timescale 1ns/1ps
`default_nettype none
module dual_audio_port_mux_bench;
	import audio_port_mux_pkg::*;
	localparam logic [7:0] OFS [8] = '{IFACE_CTRL_OFS, SEC_PINS_OFS, DIN_SEL_OFS, CLK_SRC_OFS,
		IO_ONE_FUNC_OFS, DOUT_FUNC_OFS, STATUS_OFS, 8'h10};
	localparam logic [7:0] RV [8] = '{IFACE_CTRL_RST, SEC_PINS_RST, DIN_SEL_RST, CLK_SRC_RST,
		IO_ONE_FUNC_RST, DOUT_FUNC_RST, 8'h00, 8'h00};
	localparam logic [3:0] FN [8] = '{IO_SEC_WCLK, IO_SEC_BCLK, IO_SEC_INPUT, IO_SEC_DOUT,
		IO_REC_FRAME, 4'h0, IO_SEC_INPUT, IO_REC_FRAME};
	localparam logic [2:0] DF [4] = '{DOUT_PRI_DATA, DOUT_SEC_WCLK, DOUT_SEC_BCLK, 3'h0};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	pin_drive_t word_drv, bit_drv, io_drv;
	logic word_lvl, bit_lvl, data_lvl, host_word, host_bit, serial_out;
	logic io_host = 1'b0;
	logic run = 1'b0;
	logic data_bit = 1'b0;
	logic cap = 1'b0;
	logic rnd_ready = 1'b0;
	logic ready_fix = 1'b0;
	logic bit_ready = 1'b0;
	logic bit_valid, bit_value, bit_stall;
	iface_src_t src = '0;
	iface_in_t iin;
	logic [31:0] seed = 32'd71482;
	logic [31:0] rs = 32'd71482;
	logic [7:0] v, r27, r31, r32, r33, r51, r53;
	logic exp_q[$];
	logic got_q[$];
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	// secondary host sits on io pin one whenever the device leaves it
	wire logic io_lvl = (io_drv.oe_n === 1'b0) ? io_drv.out : io_host;

	always #50 clk = ~clk;

	dual_audio_port_mux dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .word_clock_pin_in(word_lvl),
		.word_clock_pin(word_drv), .bit_clock_pin_in(bit_lvl), .bit_clock_pin(bit_drv),
		.serial_data_in_pin(data_lvl), .serial_data_out_pin(serial_out),
		.general_io_pin_one_in(io_lvl), .general_io_pin_one(io_drv), .iface_src(src),
		.iface_in(iin), .bit_valid(bit_valid), .bit_value(bit_value), .bit_ready(bit_ready),
		.bit_stall(bit_stall));

	host_port_model host (.run(run), .data_bit(data_bit), .word_drv(word_drv), .bit_drv(bit_drv),
		.word_lvl(word_lvl), .bit_lvl(bit_lvl), .data_lvl(data_lvl), .host_word(host_word),
		.host_bit(host_bit));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
	endfunction

	// expected pin picture from the six routing registers and the sources
	function automatic logic [10:0] expect_pins(input logic g, input logic pd);
		logic sw, sb, sd, pwo, pw, pbo, pb, swo, sbo, sdo, dout, ioe, ioo, rec;
		sw = (r31[4:2] == PIN_IO_ONE) ? g : 1'b0;
		sb = (r31[7:5] == PIN_IO_ONE) ? g : 1'b0;
		sd = (r31[1:0] == SEC_DIN_IO_ONE) ? g : 1'b0;
		pwo = (r33[5:4] == WSRC_PLAYBACK) ? src.play_rate : (r33[5:4] == WSRC_RECORD) ? src.rec_rate : sw;
		pw = r27[2] ? pwo : host_word;
		pbo = r33[7] ? sb : src.bit_clk;
		pb = r27[3] ? pbo : host_bit;
		swo = (r33[3:2] == WSRC_PLAYBACK) ? src.play_rate : (r33[3:2] == WSRC_RECORD) ? src.rec_rate : pw;
		sbo = r33[6] ? src.bit_clk : pb;
		sdo = r33[0] ? src.data : pd;
		dout = 1'b0;
		if (r53[3:1] == DOUT_PRI_DATA) dout = r33[1] ? sd : src.data;
		if (r53[3:1] == DOUT_SEC_WCLK) dout = swo;
		if (r53[3:1] == DOUT_SEC_BCLK) dout = sbo;
		ioe = 1'b0;
		case (r51[5:2])
			IO_SEC_WCLK: ioo = swo;
			IO_SEC_BCLK: ioo = sbo;
			IO_SEC_DOUT: ioo = sdo;
			IO_REC_FRAME: ioo = src.rec_rate;
			default: begin
				ioe = 1'b1;
				ioo = 1'b0;
			end
		endcase
		rec = !r32[1] ? pw : (r32[7:5] == 3'h0 && r51[5:2] != IO_REC_FRAME) ? g : src.rec_rate;
		// low nibble follows the interface carrier order: frame, record frame, bit clock, data
		return {~r27[2], r27[2] & pwo, ~r27[3], r27[3] & pbo, dout, ioe, ~ioe & ioo, pw, rec, pb,
			r32[0] ? sd : pd};
	endfunction

	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1;
		cmp(nm, e, reg_rdata);
	endtask

	// order kept and exactly the dropped bits missing from the end of the list
	task automatic drain_cmp(input int drops);
		cmp("popped count", 8'(exp_q.size() - drops), 8'(got_q.size()));
		while (got_q.size() > 0 && exp_q.size() > 0) cmp("popped bit", exp_q.pop_front(), got_q.pop_front());
		exp_q.delete();
		got_q.delete();
		cmp("valid after drain", 8'h00, bit_valid);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		rs <= lfsr(rs);
		bit_ready <= rnd_ready ? rs[3] : ready_fix;
		if (bit_valid === 1'b1 && bit_ready === 1'b1) got_q.push_back(bit_value);
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end

	always @(posedge bit_lvl) begin
		if (cap) exp_q.push_back(data_lvl);
	end

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd_chk("reset value", OFS[i], RV[i]);
		// status and an unmapped place keep reading zero after writes
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			bus(1'b1, 1'b0, OFS[i], seed[7:0]);
			rd_chk("readback", OFS[i], i < 6 ? seed[7:0] : 8'h00);
		end
		$display("registers done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		// secondary host stays idle while the primary host streams
		cap = 1'b1;
		rnd_ready <= 1'b1;
		run <= 1'b1;
		repeat (100) begin
			seed = lfsr(seed);
			@(posedge clk);
			data_bit <= seed[0];
		end
		run <= 1'b0;
		repeat (12) @(posedge clk);
		cap = 1'b0;
		rnd_ready <= 1'b0;
		ready_fix <= 1'b1;
		repeat (8) @(posedge clk);
		drain_cmp(0);
		$display("stream done");
		ready_fix <= 1'b0;
		cap = 1'b1;
		run = 1'b1;
		repeat (5) @(posedge host_bit);
		run = 1'b0;
		repeat (12) @(posedge clk);
		cap = 1'b0;
		#1;
		cmp("stall flag", 8'h01, bit_stall);
		rd_chk("overrun count", STATUS_OFS, 8'h03);
		ready_fix <= 1'b1;
		repeat (8) @(posedge clk);
		drain_cmp(3);
		$display("stall done");
		for (int k = 0; k < 40; k++) begin
			seed = lfsr(seed);
			v = seed[7:0];
			src <= iface_src_t'(v[3:0]);
			io_host <= v[4];
			data_bit <= v[5];
			r27 = {4'h0, v[7:6], 2'h0};
			seed = lfsr(seed);
			r33 = seed[7:0];
			seed = lfsr(seed);
			v = seed[7:0];
			r51 = {2'h0, FN[v[2:0]], 2'h0};
			r53 = {4'h0, DF[v[4:3]], 1'b0};
			// io pin one as an output must not loop back into the secondary inputs
			if (FN[v[2:0]] inside {IO_SEC_WCLK, IO_SEC_BCLK, IO_SEC_DOUT, IO_REC_FRAME}) begin
				r31 = 8'h6d;
			end else begin
				r31 = {v[5] ? PIN_DOUT : PIN_IO_ONE, v[6] ? PIN_DOUT : PIN_IO_ONE, 1'b0, v[7]};
			end
			seed = lfsr(seed);
			r32 = {2'h0, seed[2] | (FN[v[2:0]] inside {IO_SEC_WCLK, IO_SEC_BCLK, IO_SEC_DOUT}),
				3'h0, seed[1:0]};
			bus(1'b1, 1'b0, IFACE_CTRL_OFS, r27);
			bus(1'b1, 1'b0, SEC_PINS_OFS, r31);
			bus(1'b1, 1'b0, DIN_SEL_OFS, r32);
			bus(1'b1, 1'b0, CLK_SRC_OFS, r33);
			bus(1'b1, 1'b0, IO_ONE_FUNC_OFS, r51);
			bus(1'b1, 1'b0, DOUT_FUNC_OFS, r53);
			bus(1'b0, 1'b0, 8'h00, 8'h00);
			// a driven clock pin comes back through the pin synchronisers: let the loop settle
			repeat (6) @(posedge clk);
			#1;
			v = {word_drv.oe_n, ~word_drv.oe_n & word_drv.out, bit_drv.oe_n, ~bit_drv.oe_n & bit_drv.out,
				serial_out, io_drv.oe_n, ~io_drv.oe_n & io_drv.out, 1'b0};
			cmp("primary clocks", 8'(expect_pins(io_host, data_bit) >> 7), {4'h0, v[7:4]});
			cmp("data out pin", 8'(expect_pins(io_host, data_bit) >> 6 & 1), 8'(v[3]));
			cmp("io pin one", 8'(expect_pins(io_host, data_bit) >> 4 & 3), 8'(v[2:1]));
			cmp("interface in", 8'(expect_pins(io_host, data_bit) & 15), 8'(iin));
		end
		$display("routing done");
		print_verdict();
	end
endmodule
`default_nettype wire
